// ### rtl/frs_pkg.sv
// Constants and types shared by the reset and offset setup block
package frs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] FRS_REG_STATUS = 5'h00;
  localparam logic [4:0] FRS_REG_MASK   = 5'h04;
  localparam logic [4:0] FRS_REG_STATE  = 5'h08;
  localparam logic [4:0] FRS_REG_OFFSET = 5'h0C;
  localparam logic [4:0] FRS_REG_CTRL   = 5'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         FRS_EV_W        = 3;
  localparam int         FRS_EV_INIT     = 0;
  localparam int         FRS_EV_SHORT    = 1;
  localparam int         FRS_EV_RESET    = 2;
  localparam int         FRS_CTRL_SOFT   = 0;
  localparam int         FRS_OFS_Y_POS   = 16;
  localparam logic [2:0] FRS_EV_RST_VAL  = 3'h0;
  localparam logic [2:0] FRS_MASK_RST    = 3'h0;

  // ----------------------------------------------------------------
  // Timing counts, in port clock edges
  // ----------------------------------------------------------------
  localparam logic [2:0] FRS_MIN_RST_EDGES = 3'h4;
  localparam logic [1:0] FRS_IR_DELAY      = 2'h2;

  // ----------------------------------------------------------------
  // Preset offsets
  // ----------------------------------------------------------------
  localparam int FRS_PRESET_LO = 8;
  localparam int FRS_PRESET_HI = 64;

  typedef enum logic [1:0] {
    FRS_MODE_PAR = 2'b00,
    FRS_MODE_P8  = 2'b01,
    FRS_MODE_P64 = 2'b10,
    FRS_MODE_SER = 2'b11
  } frs_mode_t;

  typedef enum logic [2:0] {
    FRS_ST_RESET = 3'b000,
    FRS_ST_WAIT  = 3'b001,
    FRS_ST_PAR_Y = 3'b010,
    FRS_ST_PAR_X = 3'b011,
    FRS_ST_SER   = 3'b100,
    FRS_ST_RUN   = 3'b101
  } frs_state_t;

endpackage

// ### rtl/frs_rst_if.sv
// Reset status carried from a port-domain reset synchroniser to the core
`timescale 1ns/1ps
interface frs_rst_if;
  logic in_reset;   // Domain held in reset
  logic req_low;    // Synchronised reset request is low
  logic release_p;  // Domain leaves reset at this port edge
  logic short_p;    // Release after too few port edges in reset

  modport src (output in_reset, output req_low, output release_p,
               output short_p);
  modport dst (input in_reset, input req_low, input release_p,
               input short_p);
endinterface

// ### rtl/frs_rst_sync.sv
// Reset synchroniser and release control for one port clock domain
`timescale 1ns/1ps
module frs_rst_sync
  import frs_pkg::*;
(
  input  wire logic clk,         // System clock
  input  wire logic nrst,        // Asynchronous reset, active low
  input  wire logic rst_req_n,   // Raw reset request, active low
  input  wire logic port_edge,   // Rising edge of this port clock
  frs_rst_if.src    rif          // Reset status to the core
);

  logic       s1_q;
  logic       s2_q;
  logic       in_reset_q;
  logic [2:0] edges_q;

  // ----------------------------------------------------------------
  // Two-stage synchroniser; the request may move at any time
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= rst_req_n;
      s2_q <= s1_q;
    end
  end

  // Release happens only on this domain's own port edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_reset_q <= 1'b1;
    end else if (!s2_q) begin
      in_reset_q <= 1'b1;
    end else if (port_edge) begin
      in_reset_q <= 1'b0;
    end
  end

  // Counts port edges seen in reset to flag a too short pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      edges_q <= 3'h0;
    end else if (rif.release_p) begin
      edges_q <= 3'h0;
    end else if (!s2_q && port_edge && edges_q < FRS_MIN_RST_EDGES) begin
      edges_q <= edges_q + 3'h1;
    end
  end

  assign rif.in_reset  = in_reset_q;
  assign rif.req_low   = ~s2_q;
  assign rif.release_p = in_reset_q & s2_q & port_edge;
  assign rif.short_p   = rif.release_p & (edges_q < FRS_MIN_RST_EDGES);

  release_edge_a : assert property (@(posedge clk) disable iff (!nrst)
    rif.release_p |=> !in_reset_q && $past(port_edge))
    else $error("release not on a port edge");

endmodule

// ### rtl/frs_fifo_reset_setup.sv
// Reset, flag preset and offset programming core of a 36-bit FIFO
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module frs_fifo_reset_setup
  import frs_pkg::*;
#(
  parameter int ADDR_W = 10,                 // FIFO depth is 2**ADDR_W
  parameter int DATA_W = 36                  // Port A data width
) (
  input  wire logic              clk,                // System clock
  input  wire logic              nrst,               // Async reset, low
  input  wire logic              fifo_reset_n,       // FIFO reset pin
  input  wire logic              port_a_clock,       // Port A clock
  input  wire logic              port_b_clock,       // Port B clock
  input  wire logic              flag_select_lo,     // Mode / serial bit
  input  wire logic              flag_select_hi,     // Mode / strobe_n
  input  wire logic              port_a_write,       // FIFO write enable
  input  wire logic [DATA_W-1:0] port_a_data,        // Write data
  input  wire logic              port_b_read,        // FIFO read enable
  input  wire logic [4:0]        avs_address,        // Byte address
  input  wire logic              avs_read,           // Read request
  input  wire logic              avs_write,          // Write request
  input  wire logic [31:0]       avs_writedata,      // Write data
  output logic      [31:0]       avs_readdata,       // Read data
  output logic                   avs_waitrequest,    // Stall request
  output logic                   irq,                // Interrupt, high
  output logic                   input_ready_flag,   // Port A ready
  output logic                   output_ready_flag,  // Port B ready
  output logic                   almost_empty_flag_n, // Almost empty
  output logic                   almost_full_flag_n, // Almost full
  output logic                   mail_to_b_full_n,   // Mail to B, low
  output logic                   mail_to_a_full_n    // Mail to A, low
);

  localparam int OFS_W = ADDR_W;
  localparam int PTR_W = ADDR_W + 1;
  localparam int SER_BITS = 2 * OFS_W;
  localparam int SER_CW = $clog2(SER_BITS + 1);
  localparam logic [PTR_W-1:0] DEPTH = PTR_W'(2 ** ADDR_W);
  localparam logic [SER_CW-1:0] SER_LAST = SER_CW'(SER_BITS);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  // ----------------------------------------------------------------
  // Port clock edges and reset domains
  // ----------------------------------------------------------------
  logic pa_q;
  logic pb_q;
  logic pa_edge;
  logic pb_edge;
  logic soft_rst_q;
  logic rst_req_n;
  logic serial_offset_bit;
  logic serial_load_strobe_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pa_q <= 1'b0;
      pb_q <= 1'b0;
    end else begin
      pa_q <= port_a_clock;
      pb_q <= port_b_clock;
    end
  end

  assign pa_edge              = rise(port_a_clock, pa_q);
  assign pb_edge              = rise(port_b_clock, pb_q);
  assign rst_req_n            = fifo_reset_n & ~soft_rst_q;
  assign serial_offset_bit    = flag_select_lo;
  assign serial_load_strobe_n = flag_select_hi;

  frs_rst_if a_if ();
  frs_rst_if b_if ();

  frs_rst_sync u_sync_a (
    .clk       (clk),
    .nrst      (nrst),
    .rst_req_n (rst_req_n),
    .port_edge (pa_edge),
    .rif       (a_if.src)
  );

  frs_rst_sync u_sync_b (
    .clk       (clk),
    .nrst      (nrst),
    .rst_req_n (rst_req_n),
    .port_edge (pb_edge),
    .rif       (b_if.src)
  );

  // ----------------------------------------------------------------
  // Mode capture and setup sequence (port A domain)
  // ----------------------------------------------------------------
  frs_mode_t         mode_q;
  frs_state_t        st_q;
  logic [1:0]        wait_q;
  logic [SER_CW-1:0] ser_cnt_q;
  logic [OFS_W-1:0]  x_q;
  logic [OFS_W-1:0]  y_q;
  logic              ir_q;
  logic              wr_take;
  logic [PTR_W-1:0]  wr_ptr_q;
  logic [PTR_W-1:0]  rd_ptr_q;
  logic [PTR_W-1:0]  count;

  // Sampled while the request is still low, so the value that stood at
  // the rising edge of reset is the one kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= FRS_MODE_PAR;
    end else if (a_if.req_low) begin
      mode_q <= frs_mode_t'({flag_select_hi, flag_select_lo});
    end
  end

  assign wr_take = pa_edge & port_a_write & ir_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q      <= FRS_ST_RESET;
      wait_q    <= 2'h0;
      ser_cnt_q <= '0;
      ir_q      <= 1'b0;
    end else if (a_if.release_p) begin
      wait_q    <= 2'h0;
      ser_cnt_q <= '0;
      ir_q      <= 1'b0;
      st_q      <= (mode_q == FRS_MODE_SER) ? FRS_ST_SER : FRS_ST_WAIT;
    end else if (a_if.in_reset) begin
      st_q <= FRS_ST_RESET;
      ir_q <= 1'b0;
    end else if (pa_edge) begin
      unique case (st_q)
        FRS_ST_RESET: st_q <= FRS_ST_RESET;
        FRS_ST_WAIT: begin
          wait_q <= wait_q + 2'h1;
          if (wait_q == FRS_IR_DELAY - 2'h1) begin
            ir_q <= 1'b1;
            st_q <= (mode_q == FRS_MODE_PAR) ? FRS_ST_PAR_Y : FRS_ST_RUN;
          end
        end
        FRS_ST_PAR_Y: if (port_a_write) st_q <= FRS_ST_PAR_X;
        FRS_ST_PAR_X: if (port_a_write) st_q <= FRS_ST_RUN;
        FRS_ST_SER: begin
          if (ser_cnt_q == SER_LAST) begin
            ir_q <= 1'b1;
            st_q <= FRS_ST_RUN;
          end else if (!serial_load_strobe_n) begin
            ser_cnt_q <= ser_cnt_q + SER_CW'(1);
          end
        end
        FRS_ST_RUN: st_q <= FRS_ST_RUN;
        default: st_q <= FRS_ST_RESET;
      endcase
    end
  end

  // Offset registers: X sets almost empty, Y sets almost full
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      x_q <= '0;
      y_q <= '0;
    end else if (a_if.release_p && mode_q == FRS_MODE_P8) begin
      x_q <= OFS_W'(FRS_PRESET_LO);
      y_q <= OFS_W'(FRS_PRESET_LO);
    end else if (a_if.release_p && mode_q == FRS_MODE_P64) begin
      x_q <= OFS_W'(FRS_PRESET_HI);
      y_q <= OFS_W'(FRS_PRESET_HI);
    end else if (wr_take && st_q == FRS_ST_PAR_Y) begin
      y_q <= port_a_data[OFS_W-1:0];
    end else if (wr_take && st_q == FRS_ST_PAR_X) begin
      x_q <= port_a_data[OFS_W-1:0];
    end else if (pa_edge && st_q == FRS_ST_SER && !serial_load_strobe_n
                 && ser_cnt_q != SER_LAST) begin
      {y_q, x_q} <= {y_q[OFS_W-2:0], x_q, serial_offset_bit};
    end
  end

  // ----------------------------------------------------------------
  // Pointers and flags; storage itself lies outside this block
  // ----------------------------------------------------------------
  logic af_q;
  logic ae_q;
  logic or_q;
  logic rd_take;

  assign count   = wr_ptr_q - rd_ptr_q;
  assign rd_take = pb_edge & port_b_read & or_q;

  // A write refused when full is dropped; the source sees input ready
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      af_q     <= 1'b1;
    end else if (a_if.in_reset) begin
      wr_ptr_q <= '0;
      af_q     <= 1'b1;
    end else if (pa_edge) begin
      if (wr_take && st_q == FRS_ST_RUN && count != DEPTH) begin
        wr_ptr_q <= wr_ptr_q + PTR_W'(1);
      end
      af_q <= (DEPTH - count) > PTR_W'(y_q);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_ptr_q <= '0;
      or_q     <= 1'b0;
      ae_q     <= 1'b0;
    end else if (b_if.in_reset) begin
      rd_ptr_q <= '0;
      or_q     <= 1'b0;
      ae_q     <= 1'b0;
    end else if (pb_edge) begin
      if (rd_take) begin
        rd_ptr_q <= rd_ptr_q + PTR_W'(1);
      end
      or_q <= rd_take ? (count > PTR_W'(1)) : (count != '0);
      ae_q <= count > PTR_W'(x_q);
    end
  end

  // Mailbox transfers live elsewhere; here the flags only leave reset
  logic mb_b_q;
  logic mb_a_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mb_b_q <= 1'b1;
      mb_a_q <= 1'b1;
    end else begin
      mb_b_q <= mb_b_q | a_if.in_reset;
      mb_a_q <= mb_a_q | b_if.in_reset;
    end
  end

  // Gated by the raw request so the flags move with no clock edge, and
  // all but the mail flags by the domain state so a short pulse cannot let stale flags return
  assign input_ready_flag    = ir_q & rst_req_n & ~a_if.in_reset;
  assign output_ready_flag   = or_q & rst_req_n & ~b_if.in_reset;
  assign almost_empty_flag_n = ae_q & rst_req_n & ~b_if.in_reset;
  assign almost_full_flag_n  = af_q | ~rst_req_n | a_if.in_reset;
  assign mail_to_b_full_n    = mb_b_q | ~rst_req_n;
  assign mail_to_a_full_n    = mb_a_q | ~rst_req_n;

  // ----------------------------------------------------------------
  // Events, interrupt and Avalon-MM slave
  // ----------------------------------------------------------------
  logic                ir_prev_q;
  logic                inr_prev_q;
  logic [FRS_EV_W-1:0] ev;
  logic [FRS_EV_W-1:0] status_q;
  logic [FRS_EV_W-1:0] mask_q;
  logic                ack_q;
  logic                bus_req;
  logic                bus_wr;
  logic [31:0]         rd_mux;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ir_prev_q  <= 1'b0;
      inr_prev_q <= 1'b1;
    end else begin
      ir_prev_q  <= ir_q;
      inr_prev_q <= a_if.in_reset;
    end
  end

  always_comb begin
    ev               = '0;
    ev[FRS_EV_INIT]  = ir_q & ~ir_prev_q;
    ev[FRS_EV_SHORT] = a_if.short_p | b_if.short_p;
    ev[FRS_EV_RESET] = a_if.in_reset & ~inr_prev_q;
  end

  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign bus_wr          = avs_write & ack_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // A new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= FRS_EV_RST_VAL;
    end else if (bus_wr && avs_address == FRS_REG_STATUS) begin
      status_q <= (status_q & ~avs_writedata[FRS_EV_W-1:0]) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q     <= FRS_MASK_RST;
      soft_rst_q <= 1'b0;
    end else if (bus_wr && avs_address == FRS_REG_MASK) begin
      mask_q <= avs_writedata[FRS_EV_W-1:0];
    end else if (bus_wr && avs_address == FRS_REG_CTRL) begin
      soft_rst_q <= avs_writedata[FRS_CTRL_SOFT];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      FRS_REG_STATUS: rd_mux[FRS_EV_W-1:0] = status_q;
      FRS_REG_MASK:   rd_mux[FRS_EV_W-1:0] = mask_q;
      FRS_REG_STATE:  rd_mux[8:0] = {b_if.in_reset, a_if.in_reset, or_q,
                                     ir_q, st_q, mode_q};
      FRS_REG_OFFSET: begin
        rd_mux[OFS_W-1:0]                     = x_q;
        rd_mux[FRS_OFS_Y_POS+OFS_W-1:FRS_OFS_Y_POS] = y_q;
      end
      FRS_REG_CTRL:   rd_mux[FRS_CTRL_SOFT] = soft_rst_q;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // Data is latched in the stall cycle so it stands at the answer edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rd_mux;
    end
  end

  assign irq = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [1:0] pa_since_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pa_since_q <= 2'h0;
    end else if (a_if.release_p) begin
      pa_since_q <= 2'h0;
    end else if (pa_edge && pa_since_q != 2'h3) begin
      pa_since_q <= pa_since_q + 2'h1;
    end
  end

  ptr_clear_a : assert property (a_if.in_reset && b_if.in_reset |=>
    wr_ptr_q == '0 && rd_ptr_q == '0)
    else $error("pointers not cleared in reset");
  ready_low_a : assert property (!rst_req_n |->
    !input_ready_flag && !output_ready_flag)
    else $error("ready flag high in reset");
  ir_reset_a : assert property (a_if.in_reset |=> !ir_q)
    else $error("input ready register set in reset");
  almost_force_a : assert property (!rst_req_n |->
    !almost_empty_flag_n && almost_full_flag_n)
    else $error("almost flags not forced");
  mail_reset_a : assert property (a_if.in_reset |->
    mail_to_b_full_n && mail_to_a_full_n)
    else $error("mailbox flag low in reset");
  ir_delay_a : assert property ($rose(ir_q) && mode_q != FRS_MODE_SER |->
    pa_since_q == FRS_IR_DELAY)
    else $error("input ready raised at wrong edge");
  preset_load_a : assert property (a_if.release_p &&
    mode_q == FRS_MODE_P64 |=> x_q == OFS_W'(FRS_PRESET_HI)
    && y_q == OFS_W'(FRS_PRESET_HI))
    else $error("preset not loaded");
  mode_hold_a : assert property (!a_if.req_low && a_if.in_reset |=>
    $stable(mode_q))
    else $error("mode moved after release");
  par_load_a : assert property (wr_take && st_q == FRS_ST_PAR_Y |=>
    y_q == $past(port_a_data[OFS_W-1:0]) && $stable(wr_ptr_q))
    else $error("full offset not loaded");
  serial_ir_a : assert property (st_q == FRS_ST_SER |-> !ir_q)
    else $error("input ready high during serial load");
  set_wins_a : assert property (ev[FRS_EV_SHORT] |=>
    status_q[FRS_EV_SHORT])
    else $error("event lost on clear");

  preset_cov : cover property (a_if.release_p && mode_q == FRS_MODE_P8
    ##[1:40] $rose(ir_q));
  parallel_cov : cover property (st_q == FRS_ST_PAR_X && wr_take);
  serial_cov : cover property (st_q == FRS_ST_SER ##1 st_q == FRS_ST_RUN);
  short_cov : cover property (ev[FRS_EV_SHORT]);

endmodule

// ### tb/frs_port_model.sv
// Port-side partner: port clocks, FIFO reset pin, flag selects, writer
`timescale 1ns/1ps
module frs_port_model
  import frs_pkg::*;
(
  input  wire logic        clk,              // System clock
  input  wire logic        input_ready_flag, // Port A ready
  output logic             port_a_clock,     // Port A clock, 4 clk period
  output logic             port_b_clock,     // Port B clock, 6 clk period
  output logic             fifo_reset_n,     // FIFO reset pin
  output logic             flag_select_lo,   // Mode bit 0 / serial bit
  output logic             flag_select_hi,   // Mode bit 1 / strobe_n
  output logic             port_a_write,     // Port A write enable
  output logic [35:0]      port_a_data,      // Port A write data
  output logic             port_b_read       // Port B read, never used
);
  logic [1:0] a_cnt_q = 2'h0;
  logic [2:0] b_cnt_q = 3'h0;

  assign port_a_clock = a_cnt_q[1];
  assign port_b_clock = (b_cnt_q >= 3'h3);
  assign port_b_read  = 1'b0;

  initial begin
    fifo_reset_n   = 1'b0;
    flag_select_lo = 1'b0;
    flag_select_hi = 1'b0;
    port_a_write   = 1'b0;
    port_a_data    = 36'h0;
  end

  always_ff @(posedge clk) begin
    a_cnt_q <= a_cnt_q + 2'h1;
  end

  always_ff @(posedge clk) begin
    b_cnt_q <= (b_cnt_q == 3'h5) ? 3'h0 : b_cnt_q + 3'h1;
  end

  // ----------------------------------------------------------------
  // Drive tasks; except in hold_reset and release_reset, each change lands at the clk edge where port A rises
  // ----------------------------------------------------------------
  task automatic a_edge();
    @(posedge clk iff a_cnt_q == 2'h1);
  endtask

  task automatic hold_reset(input logic [1:0] mode);
    @(posedge clk);
    fifo_reset_n <= 1'b0;
    {flag_select_hi, flag_select_lo} <= mode;
  endtask

  // 40 clk gives ten port A and six port B edges even after the sync
  task automatic release_reset();
    repeat (40) @(posedge clk);
    fifo_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    flag_select_hi <= 1'b1;
    flag_select_lo <= 1'b0;
  endtask

  task automatic put(input logic [35:0] d);
    a_edge();
    port_a_write <= 1'b1;
    port_a_data  <= d;
  endtask

  task automatic stop();
    a_edge();
    port_a_write <= 1'b0;
    port_a_data  <= ~port_a_data;
  endtask

  task automatic load(input logic [1:0] mode, input logic [19:0] bits);
    if (mode == FRS_MODE_SER) begin
      repeat (8) @(posedge clk);
      for (int i = 19; i >= 0; i--) begin
        a_edge();
        flag_select_hi <= 1'b0;
        flag_select_lo <= bits[i];
      end
      a_edge();
      flag_select_hi <= 1'b1;
      flag_select_lo <= ~bits[0];
    end else if (mode == FRS_MODE_PAR) begin
      while (input_ready_flag !== 1'b1) @(posedge clk);
      put({26'h0, bits[19:10]});
      put({26'h0, bits[9:0]});
      stop();
    end
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the FIFO reset and offset setup block
`timescale 1ns/1ps
module testbench
  import frs_pkg::*;
;
  logic clk, nrst, avs_read, avs_write;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, q;
  wire  [31:0] avs_readdata;
  wire  avs_waitrequest, irq, ir, orf, ae_n, af_n, mb_n, ma_n;
  wire  pa_clk, pb_clk, frst_n, fs_lo, fs_hi, pa_wr, pb_rd;
  wire  [35:0] pa_data;
  wire  [5:0]  flags = {ir, orf, ae_n, af_n, mb_n, ma_n};
  int fail_count, n_checks;
  // Rows: mode, then Y and X to load, which are also the expected offsets
  localparam logic [21:0] ROWS [4] = '{{FRS_MODE_PAR, 10'h3A5, 10'h01F},
    {FRS_MODE_SER, 10'h2C3, 10'h0F1}, {FRS_MODE_P64, 10'h040, 10'h040},
    {FRS_MODE_P8, 10'h008, 10'h008}};

  frs_fifo_reset_setup i_frs_fifo_reset_setup (.clk(clk), .nrst(nrst),
    .fifo_reset_n(frst_n), .port_a_clock(pa_clk), .port_b_clock(pb_clk),
    .flag_select_lo(fs_lo), .flag_select_hi(fs_hi), .port_a_write(pa_wr),
    .port_a_data(pa_data), .port_b_read(pb_rd), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .input_ready_flag(ir),
    .output_ready_flag(orf), .almost_empty_flag_n(ae_n),
    .almost_full_flag_n(af_n), .mail_to_b_full_n(mb_n),
    .mail_to_a_full_n(ma_n));

  frs_port_model i_frs_port_model (.clk(clk), .input_ready_flag(ir),
    .port_a_clock(pa_clk), .port_b_clock(pb_clk), .fifo_reset_n(frst_n),
    .flag_select_lo(fs_lo), .flag_select_hi(fs_hi), .port_a_write(pa_wr),
    .port_a_data(pa_data), .port_b_read(pb_rd));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    n = 0;
    // No limit here: only the watchdog ends an answer that never comes
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    chk("wait_cycles", 32'h2, n);
  endtask

  task automatic wait_ir();
    int n;
    n = 0;
    while (ir !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("ir_rise", 32'h1, {31'h0, ir});
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial begin
    {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
    fail_count = 0;
    n_checks   = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      i_frs_port_model.hold_reset(ROWS[i][21:20]);
      #1 chk("reset_flags", 32'h07, {26'h0, flags});
      i_frs_port_model.release_reset();
      repeat (4) @(posedge clk);
      #1 chk("ir_hold", 32'h0, {31'h0, ir});
      i_frs_port_model.load(ROWS[i][21:20], ROWS[i][19:0]);
      wait_ir();
      bus(1'b0, FRS_REG_STATE, 32'h0);
      chk("state", {30'h0, ROWS[i][21:20]},
          {28'h0, q[8:7], q[1:0]});
      bus(1'b0, FRS_REG_OFFSET, 32'h0);
      chk("offsets",
          {6'h0, ROWS[i][19:10], 6'h0, ROWS[i][9:0]}, q);
    end
    // Fill past the preset-8 threshold, then reset from software
    for (int k = 0; k < 12; k++) i_frs_port_model.put(36'(k));
    i_frs_port_model.stop();
    repeat (40) @(posedge clk);
    #1 chk("filled", 32'h3F, {26'h0, flags});
    bus(1'b1, FRS_REG_STATUS, 32'h7);
    bus(1'b1, FRS_REG_MASK, 32'h1);
    #1 chk("irq_clear", 32'h0, {31'h0, irq});
    bus(1'b1, FRS_REG_CTRL, 32'h1);
    #1 chk("soft_flags", 32'h07, {26'h0, flags});
    repeat (40) @(posedge clk);
    bus(1'b1, FRS_REG_CTRL, 32'h0);
    wait_ir();
    repeat (30) @(posedge clk);
    #1 chk("emptied", 32'h27, {26'h0, flags});
    chk("irq_set", 32'h1, {31'h0, irq});
    bus(1'b0, FRS_REG_STATUS, 32'h0);
    chk("status", 32'h5, q);
    bus(1'b1, FRS_REG_STATUS, 32'h1);
    #1 chk("irq_w1c", 32'h0, {31'h0, irq});
    // Pulse shorter than four edges of either port clock
    bus(1'b1, FRS_REG_CTRL, 32'h1);
    bus(1'b1, FRS_REG_CTRL, 32'h0);
    #1 chk("short_ir", 32'h0, {31'h0, ir});
    repeat (40) @(posedge clk);
    bus(1'b0, FRS_REG_STATUS, 32'h0);
    chk("short_status", 32'h7, q);
    #1 chk("short_flags", 32'h27, {26'h0, flags});
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 5'h1C, 32'h0);
    chk("unmapped", 32'h0, q);
    conclude();
  end
endmodule
